// ==== hdl/sfp_fifo.sv ====
// synchronous fifo with full, empty and programmable almost flags
`include "sfp_params.svh"
module sfp_fifo #(
    parameter int DEPTH = `SFP_DEPTH_DEF
) (
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    input  wire logic                   wr_clk,
    input  wire logic                   rd_clk,
    input  wire logic [`SFP_DATA_W-1:0] wr_data_in,
    input  wire sfp_pkg::sfp_wr_ctl_t   wr_ctl,
    input  wire sfp_pkg::sfp_rd_ctl_t   rd_ctl,
    input  wire logic                   oe_n,
    output logic      [`SFP_DATA_W-1:0] rd_data_out,
    output logic                        rd_data_oe,
    output sfp_pkg::sfp_flags_t         flags,
    output sfp_pkg::sfp_mode_t          mode
);
    import sfp_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [16:0] DEPTH_W = 17'(DEPTH);

    // ****************************************************
    // elaboration checks
    // ****************************************************
    if (DEPTH < `SFP_DEPTH_MIN || DEPTH > `SFP_DEPTH_MAX ||
        (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("depth must be a power of two from 64 to 8192");
    end

    // ****************************************************
    // functions
    // ****************************************************
    // pick the byte of the offset pair that the sequence points at
    function automatic logic [`SFP_BYTE_W-1:0] ofs_byte(
        input sfp_sel_t             sel,
        input logic [`SFP_OFS_W-1:0] e_ofs,
        input logic [`SFP_OFS_W-1:0] f_ofs
    );
        logic [`SFP_BYTE_W-1:0] b;
        case (sel)
            SFP_SEL_EMPTY_LO: b = e_ofs[`SFP_LO_BYTE];
            SFP_SEL_EMPTY_HI: b = e_ofs[`SFP_HI_BYTE];
            SFP_SEL_FULL_LO:  b = f_ofs[`SFP_LO_BYTE];
            SFP_SEL_FULL_HI:  b = f_ofs[`SFP_HI_BYTE];
            default:          b = e_ofs[`SFP_LO_BYTE];
        endcase
        return b;
    endfunction : ofs_byte

    // next position in the four-step offset sequence, wrapping
    function automatic sfp_sel_t sel_step(input sfp_sel_t sel);
        return sfp_sel_t'(2'(sel + 2'h1));
    endfunction : sel_step

    // ****************************************************
    // state
    // ****************************************************
    logic                   wr_clk_prev_reg, wr_clk_prev_next;
    logic                   rd_clk_prev_reg, rd_clk_prev_next;
    sfp_mode_t              mode_reg,        mode_next;
    logic [AW-1:0]          wr_ptr_reg,      wr_ptr_next;
    logic [AW-1:0]          rd_ptr_reg,      rd_ptr_next;
    logic [AW:0]            count_reg,       count_next;
    sfp_flags_t             flags_reg,       flags_next;
    logic [`SFP_OFS_W-1:0]  e_ofs_reg,       e_ofs_next;
    logic [`SFP_OFS_W-1:0]  f_ofs_reg,       f_ofs_next;
    sfp_sel_t               sel_reg,         sel_next;
    logic [`SFP_DATA_W-1:0] dout_reg,        dout_next;

    logic                   wr_edge, rd_edge;
    logic                   prog_mode, load_low, rd_en;
    logic                   do_write, do_read, ofs_write, ofs_read;
    logic [`SFP_DATA_W-1:0] mem_rdata;
    logic [16:0]            af_sum;

    // ****************************************************
    // strobe decode
    // ****************************************************
    // pins are synchronous, so a plain previous-value compare finds edges
    assign wr_edge   = wr_clk & ~wr_clk_prev_reg;
    assign rd_edge   = rd_clk & ~rd_clk_prev_reg;
    assign prog_mode = (mode_reg == SFP_MODE_PROG);
    assign load_low  = prog_mode & ~wr_ctl.wr_en_secondary_or_load;
    assign rd_en     = ~rd_ctl.rd_en_a_n & ~rd_ctl.rd_en_b_n;

    // both modes need primary low and second pin high to store
    assign do_write  = wr_edge & ~wr_ctl.wr_en_primary_n &
                       wr_ctl.wr_en_secondary_or_load &
                       flags_reg.full_flag_n;
    assign ofs_write = wr_edge & load_low &
                       ~wr_ctl.wr_en_primary_n;
    assign ofs_read  = rd_edge & load_low & rd_en;
    // underflow guard uses the registered flag, never the live count
    assign do_read   = rd_edge & rd_en & ~load_low &
                       flags_reg.empty_flag_n;

    // ****************************************************
    // storage
    // ****************************************************
    sfp_ram #(
        .DEPTH (DEPTH)
    ) u_ram (
        .sys_clk (sys_clk),
        .wr_en   (do_write),
        .wr_addr (wr_ptr_reg),
        .wr_data (wr_data_in),
        .rd_addr (rd_ptr_reg),
        .rd_data (mem_rdata)
    );

    // ****************************************************
    // next-state logic
    // ****************************************************
    // mode follows the pin throughout reset and freezes on release
    always_comb begin
        wr_clk_prev_next = wr_clk;
        rd_clk_prev_next = rd_clk;
        mode_next = nrst ? mode_reg
                  : sfp_mode_t'(wr_ctl.wr_en_secondary_or_load);
        wr_ptr_next = do_write ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
        rd_ptr_next = do_read  ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
        count_next  = count_reg;
        if (do_write && !do_read) begin
            count_next = (AW+1)'(count_reg + 1'b1);
        end else if (do_read && !do_write) begin
            count_next = (AW+1)'(count_reg - 1'b1);
        end
    end

    // flags: empty side moves on read edges, full side on write edges
    always_comb begin
        flags_next = flags_reg;
        af_sum     = 17'(count_next) + 17'(f_ofs_reg);
        if (rd_edge) begin
            flags_next.empty_flag_n   = (count_next != '0);
            flags_next.almost_empty_n =
                (17'(count_next) > 17'(e_ofs_reg));
        end
        if (wr_edge) begin
            flags_next.full_flag_n   =
                (17'(count_next) != DEPTH_W);
            flags_next.almost_full_n = (af_sum < DEPTH_W);
        end
    end

    // offset registers and their shared access sequence
    always_comb begin
        e_ofs_next = e_ofs_reg;
        f_ofs_next = f_ofs_reg;
        sel_next   = sel_reg;
        if (ofs_write) begin
            case (sel_reg)
                SFP_SEL_EMPTY_LO:
                    e_ofs_next[`SFP_LO_BYTE] = wr_data_in[`SFP_LO_BYTE];
                SFP_SEL_EMPTY_HI:
                    e_ofs_next[`SFP_HI_BYTE] = wr_data_in[`SFP_LO_BYTE];
                SFP_SEL_FULL_LO:
                    f_ofs_next[`SFP_LO_BYTE] = wr_data_in[`SFP_LO_BYTE];
                SFP_SEL_FULL_HI:
                    f_ofs_next[`SFP_HI_BYTE] = wr_data_in[`SFP_LO_BYTE];
                default: begin
                    e_ofs_next = e_ofs_reg;
                end
            endcase
        end
        // position is kept while the load pin is high
        if (ofs_write || ofs_read) begin
            sel_next = sel_step(sel_reg);
        end
    end

    // output register holds the last good word otherwise
    always_comb begin
        dout_next = dout_reg;
        if (do_read) begin
            dout_next = mem_rdata;
        end else if (ofs_read) begin
            dout_next = {1'b0, ofs_byte(sel_reg, e_ofs_reg, f_ofs_reg)};
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge sys_clk) begin
        mode_reg <= mode_next;
        if (!nrst) begin
            wr_clk_prev_reg <= 1'b1;
            rd_clk_prev_reg <= 1'b1;
            wr_ptr_reg      <= '0;
            rd_ptr_reg      <= '0;
            count_reg       <= '0;
            flags_reg       <= '{full_flag_n: 1'b1, almost_full_n: 1'b1,
                                 almost_empty_n: 1'b0,
                                 empty_flag_n: 1'b0};
            e_ofs_reg       <= `SFP_OFS_RESET;
            f_ofs_reg       <= `SFP_OFS_RESET;
            sel_reg         <= SFP_SEL_EMPTY_LO;
            dout_reg        <= `SFP_DATA_RESET;
        end else begin
            wr_clk_prev_reg <= wr_clk_prev_next;
            rd_clk_prev_reg <= rd_clk_prev_next;
            wr_ptr_reg      <= wr_ptr_next;
            rd_ptr_reg      <= rd_ptr_next;
            count_reg       <= count_next;
            flags_reg       <= flags_next;
            e_ofs_reg       <= e_ofs_next;
            f_ofs_reg       <= f_ofs_next;
            sel_reg         <= sel_next;
            dout_reg        <= dout_next;
        end
    end

    assign rd_data_out = dout_reg;
    assign rd_data_oe  = ~oe_n;
    assign flags       = flags_reg;
    assign mode        = mode_reg;

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // queue reads: one the queue can serve, one it must refuse
    sequence s_queue_read;
        rd_edge && rd_en && !load_low && flags.empty_flag_n;
    endsequence

    sequence s_empty_read;
        rd_edge && rd_en && !load_low && !flags.empty_flag_n;
    endsequence

    // offset accesses: load low with a write edge or a read edge
    sequence s_ofs_write;
        wr_edge && load_low && !wr_ctl.wr_en_primary_n;
    endsequence

    sequence s_ofs_read;
        rd_edge && load_low && rd_en;
    endsequence

    a_read_gives_word: assert property (
        s_queue_read |=> rd_data_out == $past(mem_rdata))
        else $error("queued word not presented after read");
    a_empty_read_hold: assert property (
        s_empty_read |=> $stable(rd_data_out))
        else $error("output changed on read of empty queue");
    a_write_refused: assert property (
        wr_edge && !flags.full_flag_n && !do_read
        |=> $stable(count_reg) && $stable(wr_ptr_reg))
        else $error("word stored while full");
    a_store_lands: assert property (
        wr_edge && !wr_ctl.wr_en_primary_n &&
        wr_ctl.wr_en_secondary_or_load && flags.full_flag_n
        |=> wr_ptr_reg == AW'($past(wr_ptr_reg) + 1'b1))
        else $error("enabled write not stored");
    a_dual_no_load: assert property (
        wr_edge && mode == SFP_MODE_DUAL && !wr_ctl.wr_en_secondary_or_load
        |=> $stable(wr_ptr_reg) && $stable(e_ofs_reg) && $stable(f_ofs_reg))
        else $error("dual mode stored with second enable low");
    a_ofs_write_land: assert property (
        s_ofs_write ##0 (sel_reg == SFP_SEL_EMPTY_LO)
        |=> e_ofs_reg[`SFP_LO_BYTE] == 8'($past(wr_data_in))
            && $stable(count_reg))
        else $error("offset write did not land in empty low byte");
    a_ofs_read_byte: assert property (
        s_ofs_read ##0 (sel_reg == SFP_SEL_FULL_LO)
        |=> rd_data_out == {1'b0, 8'($past(f_ofs_reg))})
        else $error("offset read did not show full low byte");
    a_empty_only_rd: assert property (
        !rd_edge |=> $stable(flags.empty_flag_n))
        else $error("empty flag moved without read edge");
    a_empty_set: assert property (
        rd_edge && count_next == '0 |=> !flags.empty_flag_n)
        else $error("empty flag not low on empty queue");
    a_full_only_wr: assert property (
        !wr_edge |=> $stable(flags.full_flag_n))
        else $error("full flag moved without write edge");
    a_full_set: assert property (
        wr_edge && 17'(count_next) == DEPTH_W
        |=> !flags.full_flag_n)
        else $error("full flag not low on full queue");
    // expected levels rebuilt from count and offset, not from af_sum
    a_almost_empty: assert property (
        rd_edge |=> flags.almost_empty_n ==
            (17'($past(count_next)) > 17'($past(e_ofs_reg))))
        else $error("almost empty wrong against offset");
    a_almost_full: assert property (
        wr_edge |=> flags.almost_full_n ==
            (17'($past(count_next)) + 17'($past(f_ofs_reg)) < DEPTH_W))
        else $error("almost full wrong against offset");
    a_ofs_sequence: assert property (
        ofs_write |=> sel_reg == sfp_sel_t'(2'($past(sel_reg) + 2'h1)))
        else $error("offset sequence did not advance");
    a_mode_capture: assert property (
        $rose(nrst) |-> mode_reg == sfp_mode_t'(
            $past(wr_ctl.wr_en_secondary_or_load)))
        else $error("mode not taken from pin at reset");
    a_reset_state: assert property (
        $rose(nrst) |-> !flags.empty_flag_n && sel_reg == SFP_SEL_EMPTY_LO
            && e_ofs_reg == `SFP_OFS_RESET && f_ofs_reg == `SFP_OFS_RESET)
        else $error("reset state wrong");
    a_oe_drive: assert property (
        rd_data_oe == !oe_n)
        else $error("output enable polarity wrong");
endmodule : sfp_fifo

// ==== hdl/sfp_params.svh ====
// constants for the synchronous fifo with programmable flags
// Behaviour
// - each input and output transfer carries one 9-bit word
// - flag mode: store on write edge when primary enable low, load high, full high
// - dual mode: store needs primary low, secondary high, full high
// - dual-purpose pin level during reset picks dual-enable or flag mode
// - no word is stored while the full flag is low
// - flag mode with load low: write edge fills an offset register
// - read edge outputs next word when both read enables low, not empty
// - load low: read edges put offset register contents on the outputs
// - empty flag low when no words; updated on read edges only
// - full flag low when no free location; updated on write edges only
// - almost-empty low from fill level against the empty offset
// - almost-full low from free space against the full offset
// - reset is needed before use and leaves the queue empty
// - data outputs drive while output enable low, float while high
// - offset accesses cycle empty lo, empty hi, full lo, full hi, wrap
// - both offsets default to seven words after reset
// - almost-empty low at n or fewer words, high from n plus one
// - reads on an empty queue keep the last good word on the outputs
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH

`define SFP_DATA_W     9
`define SFP_BYTE_W     8
`define SFP_OFS_W      16
`define SFP_LO_BYTE    7:0
`define SFP_HI_BYTE    15:8
`define SFP_OFS_RESET  16'h0007
`define SFP_DEPTH_DEF  64
`define SFP_DEPTH_MIN  64
`define SFP_DEPTH_MAX  8192
`define SFP_DATA_RESET 9'h000

`endif

// ==== hdl/sfp_pkg.sv ====
// types shared by the fifo and its storage array
`include "sfp_params.svh"
package sfp_pkg;
    // mode caught from the dual-purpose pin during reset
    typedef enum logic [0:0] {
        SFP_MODE_PROG = 1'b0,
        SFP_MODE_DUAL = 1'b1
    } sfp_mode_t;

    // position in the offset register access sequence
    typedef enum logic [1:0] {
        SFP_SEL_EMPTY_LO = 2'b00,
        SFP_SEL_EMPTY_HI = 2'b01,
        SFP_SEL_FULL_LO  = 2'b10,
        SFP_SEL_FULL_HI  = 2'b11
    } sfp_sel_t;

    typedef struct packed {
        logic wr_en_primary_n;
        logic wr_en_secondary_or_load;
    } sfp_wr_ctl_t;

    typedef struct packed {
        logic rd_en_a_n;
        logic rd_en_b_n;
    } sfp_rd_ctl_t;

    typedef struct packed {
        logic full_flag_n;
        logic almost_full_n;
        logic almost_empty_n;
        logic empty_flag_n;
    } sfp_flags_t;
endpackage : sfp_pkg

// ==== hdl/sfp_ram.sv ====
// storage array of the fifo: one write port, one combinational read port
`include "sfp_params.svh"
module sfp_ram #(
    parameter int DEPTH = `SFP_DEPTH_DEF,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic                   sys_clk,
    input  wire logic                   wr_en,
    input  wire logic [AW-1:0]          wr_addr,
    input  wire logic [`SFP_DATA_W-1:0] wr_data,
    input  wire logic [AW-1:0]          rd_addr,
    output logic      [`SFP_DATA_W-1:0] rd_data
);
    import sfp_pkg::*;

    logic [`SFP_DATA_W-1:0] mem [DEPTH];

    // no reset on the array: contents are only read after being written
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule : sfp_ram

// ==== test/sfp_fifo_tb.sv ====
// self-checking bench for the fifo with programmable flags
`include "sfp_params.svh"
`define CHK_EQ(g, e) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD %0t got %h want %h", $time, g, e); end end
module sfp_fifo_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sfp_pkg::*;
    localparam int DEPTH = 64;

    logic                   sys_clk;
    logic                   nrst;
    logic                   oe_n;
    logic                   wr_clk;
    logic                   rd_clk;
    logic [`SFP_DATA_W-1:0] wr_data_in;
    logic [`SFP_DATA_W-1:0] rd_data_out;
    logic                   rd_data_oe;
    sfp_wr_ctl_t            wr_ctl;
    sfp_rd_ctl_t            rd_ctl;
    sfp_flags_t             flags;
    sfp_mode_t              mode;
    int                     miscompares = 0;
    int                     comparisons = 0;
    int                     i;
    logic [8:0] dflt [4] = '{9'h007, 9'h000, 9'h007, 9'h000};
    logic [8:0] ofs_w [4] = '{9'h003, 9'h100, 9'h002, 9'h000};
    logic [8:0] ofs_r [4] = '{9'h003, 9'h000, 9'h002, 9'h000};

    sfp_fifo #(.DEPTH(DEPTH)) dut_u (
        .sys_clk(sys_clk), .nrst(nrst), .wr_clk(wr_clk), .rd_clk(rd_clk),
        .wr_data_in(wr_data_in), .wr_ctl(wr_ctl), .rd_ctl(rd_ctl),
        .oe_n(oe_n), .rd_data_out(rd_data_out), .rd_data_oe(rd_data_oe),
        .flags(flags), .mode(mode));

    sfp_peer peer_u (
        .sys_clk(sys_clk), .wr_clk(wr_clk), .rd_clk(rd_clk),
        .wr_data_in(wr_data_in), .wr_ctl(wr_ctl), .rd_ctl(rd_ctl));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // reset for 16 cycles with the dual pin at the wanted mode level
    // pin set one cycle in, so the peer's idle levels cannot override it
    task automatic do_reset(input logic pin);
        nrst = 1'b0;
        @(posedge sys_clk);
        #1;
        peer_u.set_pin(pin);
        repeat (15) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        peer_u.set_pin(1'b1);
    endtask : do_reset

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        report_and_stop();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        oe_n = 1'b0;
        do_reset(1'b0);
        `CHK_EQ(mode, SFP_MODE_PROG)
        `CHK_EQ(flags, sfp_flags_t'(4'hc))
        `CHK_EQ(rd_data_out, 9'h000)
        // default offsets read back in sequence order
        for (i = 0; i < 4; i++) begin
            peer_u.rd(1'b0, 1'b0, 1'b0);
            `CHK_EQ(rd_data_out, dflt[i])
        end
        // program n = 3, m = 2; bit 8 of the high byte must be ignored
        for (i = 0; i < 4; i++) peer_u.wr(ofs_w[i], 1'b0, 1'b0);
        `CHK_EQ(flags, sfp_flags_t'(4'hc))
        for (i = 0; i < 4; i++) begin
            peer_u.rd(1'b0, 1'b0, 1'b0);
            `CHK_EQ(rd_data_out, ofs_r[i])
        end
        // four words; empty side moves only on a read edge
        for (i = 0; i < 4; i++) peer_u.wr(9'h100 + 9'(i), 1'b0, 1'b1);
        `CHK_EQ(flags, sfp_flags_t'(4'hc))
        peer_u.rd(1'b1, 1'b1, 1'b1);
        `CHK_EQ(flags, sfp_flags_t'(4'hf))
        peer_u.rd(1'b0, 1'b1, 1'b1);
        peer_u.rd(1'b1, 1'b0, 1'b1);
        `CHK_EQ(rd_data_out, 9'h000)
        for (i = 0; i < 4; i++) begin
            peer_u.rd(1'b0, 1'b0, 1'b1);
            `CHK_EQ(rd_data_out, 9'h100 + 9'(i))
            `CHK_EQ(flags, {2'b11, 3 - i > 3, 3 - i != 0})
        end
        peer_u.rd(1'b0, 1'b0, 1'b1);
        `CHK_EQ(rd_data_out, 9'h103)
        `CHK_EQ(flags, sfp_flags_t'(4'hc))
        // fill to the depth, then one refused write
        for (i = 0; i < DEPTH; i++) begin
            peer_u.wr(9'(i), 1'b0, 1'b1);
            `CHK_EQ(flags, {i + 1 < DEPTH, i + 3 < DEPTH, 2'b00})
        end
        peer_u.wr(9'h1ff, 1'b0, 1'b1);
        `CHK_EQ(flags, sfp_flags_t'(4'h0))
        peer_u.rd(1'b1, 1'b1, 1'b1);
        for (i = 0; i < DEPTH; i++) begin
            peer_u.rd(1'b0, 1'b0, 1'b1);
            `CHK_EQ(rd_data_out, 9'(i))
            if (i == 0) `CHK_EQ(flags.full_flag_n, 1'b0)
        end
        peer_u.rd(1'b0, 1'b0, 1'b1);
        `CHK_EQ(rd_data_out, 9'h03f)
        peer_u.wr(9'h0aa, 1'b1, 1'b1);
        peer_u.rd(1'b1, 1'b1, 1'b1);
        `CHK_EQ(flags, sfp_flags_t'(4'hc))
        // dual-enable mode, picked by a second reset mid-run
        do_reset(1'b1);
        `CHK_EQ(mode, SFP_MODE_DUAL)
        `CHK_EQ(flags, sfp_flags_t'(4'hc))
        peer_u.wr(9'h055, 1'b0, 1'b0);
        peer_u.wr(9'h0aa, 1'b1, 1'b1);
        peer_u.wr(9'h1a5, 1'b0, 1'b1);
        peer_u.rd(1'b1, 1'b1, 1'b1);
        `CHK_EQ(flags, sfp_flags_t'(4'hd))
        peer_u.rd(1'b0, 1'b0, 1'b1);
        `CHK_EQ(rd_data_out, 9'h1a5)
        `CHK_EQ(flags, sfp_flags_t'(4'hc))
        // output enable drives the bus only while low
        @(posedge sys_clk);
        #1;
        oe_n = 1'b1;
        @(posedge sys_clk);
        #1;
        `CHK_EQ(rd_data_oe, 1'b0)
        oe_n = 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK_EQ(rd_data_oe, 1'b1)
        report_and_stop();
    end
endmodule : sfp_fifo_tb

// ==== test/sfp_peer.sv ====
// writer and reader model that drives the fifo pins from sys_clk
`include "sfp_params.svh"
module sfp_peer (
    input  wire logic                   sys_clk,
    output logic                        wr_clk,
    output logic                        rd_clk,
    output logic      [`SFP_DATA_W-1:0] wr_data_in,
    output sfp_pkg::sfp_wr_ctl_t        wr_ctl,
    output sfp_pkg::sfp_rd_ctl_t        rd_ctl
);
    timeunit 1ns;
    timeprecision 1ps;
    import sfp_pkg::*;

    // idle levels: clocks low, enables off
    initial begin
        wr_clk = 1'b0;
        rd_clk = 1'b0;
        wr_data_in = 9'h000;
        wr_ctl = '{1'b1, 1'b1};
        rd_ctl = '{1'b1, 1'b1};
    end

    // dual pin level, held by the caller through reset
    task automatic set_pin(input logic v);
        wr_ctl.wr_en_secondary_or_load = v;
    endtask : set_pin

    // one write clock pulse; clock low for one cycle after, to keep spacing
    task automatic wr(input logic [8:0] d, input logic p_n, input logic s);
        @(posedge sys_clk);
        #1;
        wr_clk = 1'b1;
        wr_data_in = d;
        wr_ctl = '{p_n, s};
        @(posedge sys_clk);
        #1;
        wr_clk = 1'b0;
        wr_data_in = ~d; // released bus never shows the last word
        wr_ctl.wr_en_primary_n = 1'b1;
        @(posedge sys_clk);
        #1;
    endtask : wr

    // one read clock pulse; ld is the load pin level during it
    task automatic rd(input logic a_n, input logic b_n, input logic ld);
        @(posedge sys_clk);
        #1;
        rd_clk = 1'b1;
        rd_ctl = '{a_n, b_n};
        wr_ctl.wr_en_secondary_or_load = ld;
        @(posedge sys_clk);
        #1;
        rd_clk = 1'b0;
        rd_ctl = '{1'b1, 1'b1};
        @(posedge sys_clk);
        #1;
    endtask : rd
endmodule : sfp_peer
